// ===== core/nfh_consts.svh
// constants of the nand status and column read host controller
`ifndef NFH_CONSTS_SVH
`define NFH_CONSTS_SVH

// clock and timing
`define NFH_CLK_MHZ       100
`define NFH_CYC(ns)       ((((ns) * `NFH_CLK_MHZ) + 999) / 1000)
`define NFH_T_WP_NS       25
`define NFH_T_WH_NS       15
`define NFH_T_RP_NS       25
`define NFH_T_REH_NS      15
`define NFH_T_WHR_NS      80
`define NFH_WP_CYC        (`NFH_CYC(`NFH_T_WP_NS))
`define NFH_WH_CYC        (`NFH_CYC(`NFH_T_WH_NS))
`define NFH_RP_CYC        (`NFH_CYC(`NFH_T_RP_NS))
`define NFH_REH_CYC       (`NFH_CYC(`NFH_T_REH_NS))
`define NFH_WHR_CYC       (`NFH_CYC(`NFH_T_WHR_NS))
`define NFH_SYNC_CYC      2

// flash command bytes
`define NFH_CMD_STATUS    8'h70
`define NFH_CMD_STATUS_EN 8'h78
`define NFH_CMD_READ_MODE 8'h00
`define NFH_CMD_RAND_RD   8'h05
`define NFH_CMD_RAND_RD2  8'h06
`define NFH_CMD_CONFIRM   8'hE0

// register byte offsets
`define NFH_REG_CMD       8'h00
`define NFH_REG_COL       8'h04
`define NFH_REG_ROW       8'h08
`define NFH_REG_CFG       8'h0C
`define NFH_REG_STAT      8'h10
`define NFH_REG_DATA      8'h14

// field positions
`define NFH_CFG_MULTI     0
`define NFH_CFG_OTP       1
`define NFH_ST_BUSY       0
`define NFH_ST_ERR        1
`define NFH_ST_RB         2
`define NFH_ST_DIESEL     3
`define NFH_ST_STMODE     4

// axi responses
`define NFH_RESP_OKAY     2'h0
`define NFH_RESP_DECERR   2'h3

`endif

// ===== core/nfh_pkg.sv
// types of the nand status and column read host controller
package nfh_pkg;

    typedef enum logic [2:0] {
        OP_STATUS    = 3'h0,
        OP_STATUS_EN = 3'h1,
        OP_READ_MODE = 3'h2,
        OP_RAND_RD   = 3'h3,
        OP_RAND_RD2  = 3'h4,
        OP_RD_STATUS = 3'h5,
        OP_RD_DATA   = 3'h6,
        OP_NONE      = 3'h7
    } nfh_op_type;

    typedef enum logic [1:0] {
        CY_CMD  = 2'h0,
        CY_ADDR = 2'h1,
        CY_READ = 2'h2
    } nfh_cyc_kind_type;

    typedef struct packed {
        nfh_cyc_kind_type kind;
        logic [7:0]       data;
    } nfh_item_type;

    typedef struct packed {
        logic       ce_n;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       re_n;
        logic [7:0] io_out;
        logic       io_oe;
    } nfh_pins_type;

    typedef enum logic [1:0] {
        CS_IDLE  = 2'h0,
        CS_SETUP = 2'h1,
        CS_PULSE = 2'h2,
        CS_HOLD  = 2'h3
    } nfh_cyc_state_type;

    typedef enum logic [2:0] {
        SS_IDLE  = 3'h0,
        SS_READY = 3'h1,
        SS_ISSUE = 3'h2,
        SS_WAIT  = 3'h3,
        SS_GAP   = 3'h4
    } nfh_seq_state_type;

endpackage

// ===== core/nfh_bus_cycle.sv
// one strobed command, address or read cycle on the flash pins
`timescale 1ns/1ps
`include "nfh_consts.svh"

module nfh_bus_cycle
(
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // request
    input  wire logic          start,
    input  nfh_pkg::nfh_item_type item,
    input  wire logic          select,
    output logic               done,
    output logic [7:0]         rdata,
    // flash pins
    input  wire logic [7:0]    io_in,
    output nfh_pkg::nfh_pins_type pins
);
    nfh_pkg::nfh_cyc_state_type state_q;
    nfh_pkg::nfh_item_type      item_q;
    logic [7:0]                 cnt_q;
    logic [7:0]                 io_meta_q;
    logic [7:0]                 io_sync_q;
    nfh_pkg::nfh_pins_type      pins_q;
    logic [7:0]                 rdata_q;
    logic                       done_q;

    wire is_read  = item_q.kind == nfh_pkg::CY_READ;
    wire cnt_end  = cnt_q == 8'h01;
    // read pulse is stretched by the synchroniser depth before sampling
    wire [7:0] pulse_len = is_read ? 8'(`NFH_RP_CYC + `NFH_SYNC_CYC) : 8'(`NFH_WP_CYC);
    wire [7:0] hold_len  = is_read ? 8'(`NFH_REH_CYC) : 8'(`NFH_WH_CYC);

    always_ff @(posedge aclk)
    begin
        io_meta_q <= io_in;
        io_sync_q <= io_meta_q;
    end

    always_ff @(posedge aclk)
    begin
        done_q <= 1'b0;
        if (!aresetn)
        begin
            state_q <= nfh_pkg::CS_IDLE;
            item_q  <= '0;
            cnt_q   <= 8'h00;
            rdata_q <= 8'h00;
            pins_q  <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                         io_out: 8'h00, io_oe: 1'b0};
        end
        else
        begin
            pins_q.ce_n <= ~select;
            unique case (state_q)
                nfh_pkg::CS_IDLE:
                begin
                    if (start)
                    begin
                        item_q        <= item;
                        pins_q.cle    <= item.kind == nfh_pkg::CY_CMD;
                        pins_q.ale    <= item.kind == nfh_pkg::CY_ADDR;
                        pins_q.io_out <= item.data;
                        pins_q.io_oe  <= item.kind != nfh_pkg::CY_READ;
                        state_q       <= nfh_pkg::CS_SETUP;
                    end
                end
                nfh_pkg::CS_SETUP:
                begin
                    pins_q.we_n <= is_read;
                    pins_q.re_n <= ~is_read;
                    cnt_q       <= pulse_len;
                    state_q     <= nfh_pkg::CS_PULSE;
                end
                nfh_pkg::CS_PULSE:
                begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_end)
                    begin
                        if (is_read)
                            rdata_q <= io_sync_q;
                        pins_q.we_n <= 1'b1;
                        pins_q.re_n <= 1'b1;
                        cnt_q       <= hold_len;
                        state_q     <= nfh_pkg::CS_HOLD;
                    end
                end
                nfh_pkg::CS_HOLD:
                begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_end)
                    begin
                        pins_q.cle   <= 1'b0;
                        pins_q.ale   <= 1'b0;
                        pins_q.io_oe <= 1'b0;
                        done_q       <= 1'b1;
                        state_q      <= nfh_pkg::CS_IDLE;
                    end
                end
            endcase
        end
    end

    assign pins  = pins_q;
    assign rdata = rdata_q;
    assign done  = done_q;
endmodule

// ===== core/nfh_host.sv
// host controller for flash status reads and column-address data reads
`timescale 1ns/1ps
`include "nfh_consts.svh"

module nfh_host
(
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // axi4-lite write
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // flash pins
    input  wire logic [7:0]    io_in,
    input  wire logic          rb_n,
    output nfh_pkg::nfh_pins_type pins
);
    // register state
    logic [15:0]               col_q;
    logic [23:0]               row_q;
    logic [1:0]                cfg_q;
    logic                      err_q;
    logic                      die_sel_q;
    logic                      st_mode_q;
    logic [7:0]                data_q;
    logic                      bvalid_q;
    logic [1:0]                bresp_q;
    logic                      rvalid_q;
    logic [1:0]                rresp_q;
    logic [31:0]               rdata_q;
    // sequencer state
    nfh_pkg::nfh_seq_state_type state_q;
    nfh_pkg::nfh_op_type        op_q;
    logic [2:0]                idx_q;
    logic [7:0]                gap_q;
    logic                      rb_meta_q;
    logic                      rb_q;
    logic                      cyc_done;
    logic [7:0]                cyc_rdata;

    // bus slave decode
    wire wr_go   = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    wire rd_go   = s_axi_arvalid && !rvalid_q;
    wire wr_cmd  = wr_go && s_axi_awaddr == `NFH_REG_CMD;
    wire wr_col  = wr_go && s_axi_awaddr == `NFH_REG_COL;
    wire wr_row  = wr_go && s_axi_awaddr == `NFH_REG_ROW;
    wire wr_cfg  = wr_go && s_axi_awaddr == `NFH_REG_CFG;
    wire wr_hit  = wr_cmd || wr_col || wr_row || wr_cfg;
    wire busy    = state_q != nfh_pkg::SS_IDLE;

    wire multi   = cfg_q[`NFH_CFG_MULTI];
    wire otp     = cfg_q[`NFH_CFG_OTP];
    wire [2:0] req_code = s_axi_wdata[2:0];
    wire nfh_pkg::nfh_op_type req_op = nfh_pkg::nfh_op_type'(req_code);

    // refusal of an ordered operation that would break the bus protocol
    wire ref_70  = req_op == nfh_pkg::OP_STATUS && multi;
    wire ref_78  = req_op == nfh_pkg::OP_STATUS_EN && otp;
    wire ref_05  = req_op == nfh_pkg::OP_RAND_RD && multi && !die_sel_q;
    wire ref_06  = req_op == nfh_pkg::OP_RAND_RD2 && multi && !die_sel_q && !rb_q;
    wire ref_rs  = req_op == nfh_pkg::OP_RD_STATUS && !st_mode_q;
    wire ref_rd  = req_op == nfh_pkg::OP_RD_DATA && st_mode_q;
    wire ref_op  = req_op == nfh_pkg::OP_NONE || busy;
    wire refuse  = ref_70 || ref_78 || ref_05 || ref_06 || ref_rs || ref_rd || ref_op;
    wire launch  = wr_cmd && !refuse;

    // length of each operation in bus cycles
    wire [2:0] seq_len =
        (op_q == nfh_pkg::OP_STATUS_EN) ? 3'h4 :
        (op_q == nfh_pkg::OP_RAND_RD)   ? 3'h4 :
        (op_q == nfh_pkg::OP_RAND_RD2)  ? 3'h7 : 3'h1;
    wire last_item = idx_q == seq_len - 3'h1;
    wire ends_cmd  = op_q != nfh_pkg::OP_RD_STATUS && op_q != nfh_pkg::OP_RD_DATA;

    // byte sequence per operation
    nfh_pkg::nfh_item_type item;
    always_comb
    begin
        item = '{kind: nfh_pkg::CY_ADDR, data: 8'h00};
        unique case (op_q)
            nfh_pkg::OP_STATUS:    item = '{nfh_pkg::CY_CMD, `NFH_CMD_STATUS};
            nfh_pkg::OP_READ_MODE: item = '{nfh_pkg::CY_CMD, `NFH_CMD_READ_MODE};
            nfh_pkg::OP_STATUS_EN:
                unique case (idx_q)
                    3'h0:    item = '{nfh_pkg::CY_CMD, `NFH_CMD_STATUS_EN};
                    3'h1:    item.data = row_q[7:0];
                    3'h2:    item.data = row_q[15:8];
                    default: item.data = row_q[23:16];
                endcase
            nfh_pkg::OP_RAND_RD:
                unique case (idx_q)
                    3'h0:    item = '{nfh_pkg::CY_CMD, `NFH_CMD_RAND_RD};
                    3'h1:    item.data = col_q[7:0];
                    3'h2:    item.data = col_q[15:8];
                    default: item = '{nfh_pkg::CY_CMD, `NFH_CMD_CONFIRM};
                endcase
            nfh_pkg::OP_RAND_RD2:
                unique case (idx_q)
                    3'h0:    item = '{nfh_pkg::CY_CMD, `NFH_CMD_RAND_RD2};
                    3'h1:    item.data = col_q[7:0];
                    3'h2:    item.data = col_q[15:8];
                    3'h3:    item.data = row_q[7:0];
                    3'h4:    item.data = row_q[15:8];
                    3'h5:    item.data = row_q[23:16];
                    default: item = '{nfh_pkg::CY_CMD, `NFH_CMD_CONFIRM};
                endcase
            default:       item = '{nfh_pkg::CY_READ, 8'h00};
        endcase
    end

    wire cyc_start = state_q == nfh_pkg::SS_ISSUE;

    nfh_bus_cycle u_cycle
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (cyc_start),
        .item    (item),
        .select  (busy),
        .done    (cyc_done),
        .rdata   (cyc_rdata),
        .io_in   (io_in),
        .pins    (pins)
    );

    // ready/busy pin into the clock domain
    always_ff @(posedge aclk)
    begin
        rb_meta_q <= rb_n;
        rb_q      <= rb_meta_q;
    end

    // operation sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= nfh_pkg::SS_IDLE;
            op_q    <= nfh_pkg::OP_NONE;
            idx_q   <= 3'h0;
            gap_q   <= 8'h00;
        end
        else
        begin
            unique case (state_q)
                nfh_pkg::SS_IDLE:
                    if (launch)
                    begin
                        op_q    <= req_op;
                        idx_q   <= 3'h0;
                        state_q <= (req_op == nfh_pkg::OP_READ_MODE) ?
                                   nfh_pkg::SS_READY : nfh_pkg::SS_ISSUE;
                    end
                nfh_pkg::SS_READY:
                    if (rb_q)
                        state_q <= nfh_pkg::SS_ISSUE;
                nfh_pkg::SS_ISSUE:
                    state_q <= nfh_pkg::SS_WAIT;
                nfh_pkg::SS_WAIT:
                    if (cyc_done)
                    begin
                        idx_q <= idx_q + 3'h1;
                        if (!last_item)
                            state_q <= nfh_pkg::SS_ISSUE;
                        else if (ends_cmd)
                        begin
                            gap_q   <= 8'(`NFH_WHR_CYC);
                            state_q <= nfh_pkg::SS_GAP;
                        end
                        else
                            state_q <= nfh_pkg::SS_IDLE;
                    end
                nfh_pkg::SS_GAP:
                begin
                    gap_q <= gap_q - 8'h01;
                    if (gap_q == 8'h01)
                        state_q <= nfh_pkg::SS_IDLE;
                end
                default:
                    state_q <= nfh_pkg::SS_IDLE;
            endcase
        end
    end

    wire seq_fin = state_q == nfh_pkg::SS_WAIT && cyc_done && last_item;

    // software registers and tracked flash mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            col_q     <= 16'h0000;
            row_q     <= 24'h000000;
            cfg_q     <= 2'h0;
            err_q     <= 1'b0;
            die_sel_q <= 1'b0;
            st_mode_q <= 1'b0;
            data_q    <= 8'h00;
        end
        else
        begin
            if (wr_col)
                col_q <= s_axi_wdata[15:0];
            if (wr_row)
                row_q <= s_axi_wdata[23:0];
            if (wr_cfg)
                cfg_q <= s_axi_wdata[1:0];
            if (wr_cmd)
                err_q <= refuse;
            if (wr_cfg)
                die_sel_q <= 1'b0;
            else if (seq_fin && op_q == nfh_pkg::OP_STATUS_EN)
                die_sel_q <= 1'b1;
            if (seq_fin)
            begin
                if (op_q == nfh_pkg::OP_STATUS || op_q == nfh_pkg::OP_STATUS_EN)
                    st_mode_q <= 1'b1;
                else if (ends_cmd)
                    st_mode_q <= 1'b0;
                if (!ends_cmd)
                    data_q <= cyc_rdata;
            end
        end
    end

    // read data selection
    wire [31:0] stat_word = {27'h0000000, st_mode_q, die_sel_q, rb_q, err_q, busy};
    wire [31:0] rd_word =
        (s_axi_araddr == `NFH_REG_CMD)  ? {29'h00000000, op_q} :
        (s_axi_araddr == `NFH_REG_COL)  ? {16'h0000, col_q} :
        (s_axi_araddr == `NFH_REG_ROW)  ? {8'h00, row_q} :
        (s_axi_araddr == `NFH_REG_CFG)  ? {30'h00000000, cfg_q} :
        (s_axi_araddr == `NFH_REG_STAT) ? stat_word :
        (s_axi_araddr == `NFH_REG_DATA) ? {24'h000000, data_q} : 32'h00000000;
    wire rd_hit = s_axi_araddr <= `NFH_REG_DATA && s_axi_araddr[1:0] == 2'h0;

    // axi4-lite responses
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= `NFH_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q  <= `NFH_RESP_OKAY;
            rdata_q  <= 32'h00000000;
        end
        else
        begin
            if (wr_go)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? `NFH_RESP_OKAY : `NFH_RESP_DECERR;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
            if (rd_go)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_word;
                rresp_q  <= rd_hit ? `NFH_RESP_OKAY : `NFH_RESP_DECERR;
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
endmodule

// ===== sim/nfh_host_assertions.sv
// concurrent checks on the host controller ports
`timescale 1ns/1ps
module nfh_host_assertions
(
    // clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    // axi4-lite
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic [1:0]       s_axi_bresp,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic [31:0]      s_axi_rdata,
    // flash pins
    input nfh_pkg::nfh_pins_type pins
);
    AST_WR_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready |=> s_axi_bvalid) else $error("no write answer");
    AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_RD_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
    AST_R_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_R_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready) else $error("second read accepted");
    AST_WE_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(pins.we_n) |-> !pins.we_n [*3] ##1 pins.we_n) else $error("write strobe width");
    AST_READ_FLOAT: assert property (@(posedge aclk) disable iff (!aresetn)
        !pins.re_n |-> !pins.io_oe && !pins.ce_n && pins.we_n) else $error("host drives in read");
    AST_WHR: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(pins.we_n) && pins.cle && pins.io_out == 8'hE0 |-> pins.re_n [*8])
        else $error("read too soon after confirm");
endmodule

bind nfh_host nfh_host_assertions chk_u (.*);

// ===== sim/nfh_die_model.sv
// behavioural flash die facing the host controller
`timescale 1ns/1ps
module nfh_die_model
#(
    parameter int LUN_BIT   = 0,  // bit of third row byte picking the die
    parameter int PLANE_BIT = 6   // bit of first row byte picking the plane
)
(
    // pins from host
    input nfh_pkg::nfh_pins_type pins,
    // die state set by the bench
    input wire logic             wp_n,
    input wire logic             rdy,
    input wire logic             array_ready_flag,
    input wire logic [3:0]       fails,
    // pins to host
    output logic [7:0]           io_in,
    output logic                 rb_n
);
    logic [7:0]  cmd_q = 8'hFF;
    logic [7:0]  last_q = 8'h00;
    logic [7:0]  abuf [5];
    logic [2:0]  na_q = 3'h0;
    logic [15:0] col_q = 16'h0;
    logic        stat_q = 1'b0;
    logic        sel_q = 1'b1;
    logic        pl_q = 1'b0;
    logic [7:0]  stat_byte;
    logic [7:0]  cache_byte;
    wire         drive = !pins.ce_n && !pins.re_n && sel_q;
    // ready flags shared, fail pair per plane
    assign stat_byte  = {wp_n, rdy, array_ready_flag, 3'h0, fails[pl_q*2 +: 2]};
    assign cache_byte = col_q[7:0] ^ {pl_q, 3'h0, col_q[11:8]};
    // released bus shows the inverse of the last byte
    assign io_in = drive ? (stat_q ? stat_byte : cache_byte) : ~last_q;
    assign rb_n  = rdy;
    always @(negedge pins.re_n)
        if (drive)
            last_q <= io_in;
    always @(posedge pins.re_n)
        if (!pins.ce_n && sel_q && !stat_q)
            col_q <= col_q + 16'h1;
    always @(posedge pins.we_n)
    begin
        if (!pins.ce_n && pins.cle)
        begin
            cmd_q <= pins.io_out;
            na_q  <= 3'h0;
            if (pins.io_out == 8'h70)
                stat_q <= 1'b1;
            if (pins.io_out == 8'h00)
                stat_q <= 1'b0;
            if (pins.io_out == 8'hE0 && cmd_q == 8'h05 && rdy)
            begin
                col_q  <= {abuf[1], abuf[0]};
                stat_q <= 1'b0;
            end
            if (pins.io_out == 8'hE0 && cmd_q == 8'h06 && rdy && array_ready_flag)
            begin
                col_q  <= {abuf[1], abuf[0]};
                sel_q  <= !abuf[4][LUN_BIT];
                pl_q   <= abuf[2][PLANE_BIT];
                stat_q <= 1'b0;
            end
        end
        else if (!pins.ce_n && pins.ale)
        begin
            abuf[na_q] <= pins.io_out;
            na_q       <= na_q + 3'h1;
            if (cmd_q == 8'h78 && na_q == 3'h2)
            begin
                sel_q  <= !pins.io_out[LUN_BIT];
                pl_q   <= abuf[0][PLANE_BIT];
                stat_q <= 1'b1;
            end
        end
    end
endmodule

// ===== sim/nfh_host_bench.sv
// self-checking bench of the host controller with a die model
`timescale 1ns/1ps
`include "nfh_consts.svh"
module nfh_host_bench;
    logic                  aclk = 1'b0;
    logic                  aresetn = 1'b0;
    logic [7:0]            s_axi_awaddr = 8'h00;
    logic [7:0]            s_axi_araddr = 8'h00;
    logic [31:0]           s_axi_wdata = 32'h0;
    logic [3:0]            s_axi_wstrb = 4'hF;
    logic                  s_axi_awvalid = 1'b0;
    logic                  s_axi_wvalid = 1'b0;
    logic                  s_axi_bready = 1'b0;
    logic                  s_axi_arvalid = 1'b0;
    logic                  s_axi_rready = 1'b0;
    logic                  s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic                  s_axi_arready, s_axi_rvalid;
    logic [1:0]            s_axi_bresp, s_axi_rresp, resp;
    logic [31:0]           s_axi_rdata, rdat, rnd;
    logic [7:0]            io_in;
    logic                  rb_n;
    nfh_pkg::nfh_pins_type pins;
    logic                  wp_n = 1'b1;
    logic                  rdy = 1'b1;
    logic                  array_ready_flag = 1'b1;
    logic [3:0]            fails = 4'h0;
    logic [15:0]           col;
    logic [23:0]           row;
    int                    fail_count = 0;
    int                    comparisons = 0;
    int                    cyc = 0;

    nfh_host dut_u (.*);
    nfh_die_model model_u (.*);

    initial forever #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fail_count++;
            finish_test();
        end
    end

    function automatic logic [31:0] st_exp(input logic p);
        return {24'h0, wp_n, rdy, array_ready_flag, 3'h0, p ? fails[3:2] : fails[1:0]};
    endfunction
    function automatic logic [31:0] cb_exp(input logic p, input logic [15:0] c);
        return {24'h0, c[7:0] ^ {p, 3'h0, c[11:8]}};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        s_axi_bready  <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready  <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready  <= 1'b0;
    endtask
    task automatic op(input logic [2:0] o);
        wr(`NFH_REG_CMD, {29'h0, o});
        do rd(`NFH_REG_STAT); while (rdat[0] !== 1'b0);
    endtask
    // refused launch leaves err set and nothing running
    task automatic refuse(input logic [2:0] o);
        wr(`NFH_REG_CMD, {29'h0, o});
        rd(`NFH_REG_STAT);
    endtask
    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'h7085ebd2));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`NFH_REG_STAT);
        chk(rdat, 32'h4);
        rd(8'h18);
        chk({30'h0, resp}, 32'h3);
        wr(8'h18, 32'h5);
        chk({30'h0, resp}, 32'h3);
        repeat (6)
        begin
            rnd = $urandom();
            {wp_n, rdy, array_ready_flag, fails} <= rnd[6:0];
            op(3'h0);
            op(3'h5);
            rd(`NFH_REG_DATA);
            chk(rdat, st_exp(1'b0));
            fails <= ~fails;
            op(3'h5);
            rd(`NFH_REG_DATA);
            chk(rdat, st_exp(1'b0));
        end
        refuse(3'h6);
        chk(rdat & 32'h3, 32'h2);
        refuse(3'h7);
        chk(rdat & 32'h3, 32'h2);
        // let the synchronised ready/busy fall before ordering 00h
        rdy <= 1'b0;
        repeat (4) @(posedge aclk);
        wr(`NFH_REG_CMD, 32'h2);
        repeat (30) @(posedge aclk);
        rd(`NFH_REG_STAT);
        chk(rdat & 32'h1, 32'h1);
        rdy <= 1'b1;
        do rd(`NFH_REG_STAT); while (rdat[0] !== 1'b0);
        chk(rdat & 32'h13, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            rnd = $urandom();
            col = (i == 0) ? 16'h0 : (i == 1) ? 16'h083F : {4'h0, rnd[11:0]};
            array_ready_flag <= rnd[12];
            wr(`NFH_REG_COL, {16'h0, col});
            chk({30'h0, resp}, 32'h0);
            op(3'h3);
            op(3'h6);
            rd(`NFH_REG_DATA);
            chk(rdat, cb_exp(1'b0, col));
            op(3'h6);
            rd(`NFH_REG_DATA);
            chk(rdat, cb_exp(1'b0, col + 16'h1));
        end
        array_ready_flag <= 1'b1;
        wr(`NFH_REG_CFG, 32'h1);
        refuse(3'h0);
        chk(rdat & 32'h3, 32'h2);
        refuse(3'h3);
        chk(rdat & 32'h3, 32'h2);
        rdy <= 1'b0;
        repeat (4) @(posedge aclk);
        refuse(3'h4);
        chk(rdat & 32'h3, 32'h2);
        for (int p = 0; p < 2; p++)
        begin
            rnd = $urandom();
            row = (rnd[23:0] & 24'h00FFBF) | (p[0] ? 24'h40 : 24'h0);
            col = {4'h0, rnd[27:16]};
            {rdy, fails} <= {p[0], rnd[31:28]};
            wr(`NFH_REG_ROW, {8'h0, row});
            op(3'h1);
            op(3'h5);
            rd(`NFH_REG_DATA);
            chk(rdat, st_exp(p[0]));
            rdy <= 1'b1;
            op(3'h2);
            wr(`NFH_REG_COL, {16'h0, col});
            op(3'h4);
            op(3'h6);
            rd(`NFH_REG_DATA);
            chk(rdat, cb_exp(p[0], col));
        end
        wr(`NFH_REG_CFG, 32'h3);
        refuse(3'h1);
        chk(rdat & 32'h3, 32'h2);
        finish_test();
    end
endmodule
